// ==== vcbs_consts.vh ====
// Constants for the validity combine and bit shuffle block
`ifndef VCBS_CONSTS_VH
`define VCBS_CONSTS_VH
`define VCBS_NUM_TRK 8
`define VCBS_NUM_MUX 8
`define VCBS_CW_BITS 32
`define VCBS_CW_CNT_W 5
`define VCBS_CW_RESET 32'h00000000
`define VCBS_SEL_W 3
`define VCBS_VAR_W 2
`define VCBS_VAR_DIRECT 2'h0
`define VCBS_VAR_REMAP 2'h1
`define VCBS_VAR_SPLIT 2'h2
`define VCBS_VAR_EVEN 2'h3
`define VCBS_OUT_W 8
`endif

// ==== vcbs_skid_buf.v ====
// Two-entry buffer with valid and ready on both sides
`timescale 1ns/1ps
module vcbs_skid_buf
(
  clk,
  rst_b,
  inData,
  inValid,
  inReady,
  outData,
  outValid,
  outReady
);
  parameter WIDTH = 16;
  input wire clk;
  input wire rst_b;
  input wire [WIDTH-1:0] inData;
  input wire inValid;
  output reg inReady;
  output reg [WIDTH-1:0] outData;
  output reg outValid;
  input wire outReady;

  reg [WIDTH-1:0] spare_ff;
  reg spareValid_ff;
  reg nxt_spareValid;

  // ---------------------------------------------------------------
  // Spare entry occupancy
  // ---------------------------------------------------------------
  always @*
  begin
    nxt_spareValid = spareValid_ff;
    if (outReady || !outValid)
      nxt_spareValid = 1'b0;
    else if (inValid && inReady)
      nxt_spareValid = 1'b1;
  end

  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      outData <= {WIDTH{1'b0}};
      outValid <= 1'b0;
      spare_ff <= {WIDTH{1'b0}};
      spareValid_ff <= 1'b0;
      inReady <= 1'b0;
    end
    else
    begin
      spareValid_ff <= nxt_spareValid;
      inReady <= !nxt_spareValid;
      if (outReady || !outValid)
      begin
        if (spareValid_ff)
        begin
          outData <= spare_ff;
          outValid <= 1'b1;
        end
        else
        begin
          outData <= inData;
          outValid <= inValid && inReady;
        end
      end
      else if (inValid && inReady)
      begin
        spare_ff <= inData;
      end
    end
  end
endmodule

// ==== vcbs_validity_shuffle.v ====
// Validity combiner and programmable bit shuffler
// Functional notes
// - Eight channelized validity flags, one per cross-multiplier array.
// - Polar modes OR validities of adjacent pipelines.
// - Special polar mode two ORs pairs 0/2, 4/6, 1/3, 5/7 on top of adjacent pairs, so groups 0-3 and 4-7.
// - Pairwise OR enabled by the channel swap select.
// - Eight track inputs routed into interleaved buffer banks per variant.
// - Each variant configured by a serially loaded 32-bit control word.
// - Derived variants share the control word format of their originals.
// - Split variant: muxes 4,6 take even inputs, muxes 5,7 odd.
// - Even-only variants use even inputs and discard odd ones.
// - Direct variant maps inputs 0-7 to mux inputs 0-7.
// - Remapped variant: even to mux inputs 0-3, odd to 4-7.
`timescale 1ns/1ps
`include "vcbs_consts.vh"
module vcbs_validity_shuffle
(
  clk,
  rst_b,
  trackBits,
  chanValid,
  polarMode,
  swapSel,
  variantSel,
  cwBit,
  cwStrobe,
  cwStart,
  inValid,
  inReady,
  bankBits,
  bankValidity,
  outValid,
  outReady,
  cwActive
);
  input wire clk;
  input wire rst_b;
  input wire [`VCBS_NUM_TRK-1:0] trackBits;
  input wire [`VCBS_NUM_TRK-1:0] chanValid;
  input wire polarMode;
  input wire swapSel;
  input wire [`VCBS_VAR_W-1:0] variantSel;
  input wire cwBit;
  input wire cwStrobe;
  input wire cwStart;
  input wire inValid;
  output wire inReady;
  output wire [`VCBS_OUT_W-1:0] bankBits;
  output wire [`VCBS_NUM_TRK-1:0] bankValidity;
  output wire outValid;
  input wire outReady;
  output reg [`VCBS_CW_BITS-1:0] cwActive;

  localparam ST_IDLE = 2'b01;
  localparam ST_LOAD = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;
  reg [`VCBS_CW_BITS-1:0] cwShift_ff;
  reg [`VCBS_CW_CNT_W-1:0] cwCnt_ff;
  reg [`VCBS_NUM_TRK-1:0] validOut;
  reg [`VCBS_OUT_W-1:0] muxOut;
  wire [`VCBS_NUM_TRK-1:0] pairOr;
  wire [`VCBS_NUM_TRK-1:0] adjOr;

  // Mux select field k of the control word, same layout for every variant
  function [`VCBS_SEL_W-1:0] selField;
    input [`VCBS_CW_BITS-1:0] word;
    input integer k;
    begin
      selField = word[k*4 +: `VCBS_SEL_W];
    end
  endfunction

  // Route one mux input index to a track per the wiring variant
  function trackPick;
    input [`VCBS_VAR_W-1:0] variant;
    input integer mux;
    input [`VCBS_SEL_W-1:0] sel;
    input [`VCBS_NUM_TRK-1:0] trk;
    begin
      case (variant)
        `VCBS_VAR_DIRECT: trackPick = trk[sel];
        `VCBS_VAR_REMAP: trackPick = sel[2] ? trk[{sel[1:0], 1'b1}]
                                            : trk[{sel[1:0], 1'b0}];
        `VCBS_VAR_SPLIT:
        begin
          if (mux >= 4)
            trackPick = (mux % 2 == 0) ? trk[{sel[1:0], 1'b0}]
                                       : trk[{sel[1:0], 1'b1}];
          else
            trackPick = trk[sel];
        end
        `VCBS_VAR_EVEN: trackPick = trk[{sel[1:0], 1'b0}];
        default: trackPick = 1'b0;
      endcase
    end
  endfunction

  // ---------------------------------------------------------------
  // Serial control word loader
  // ---------------------------------------------------------------
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
        if (cwStart)
          nxt_state = ST_LOAD;
      ST_LOAD:
        if (cwStrobe && cwCnt_ff == `VCBS_CW_BITS - 1)
          nxt_state = ST_IDLE;
      default: nxt_state = ST_IDLE;
    endcase
  end

  always @(posedge clk)
  begin
    if (!rst_b)
    begin
      state_ff <= ST_IDLE;
      cwShift_ff <= `VCBS_CW_RESET;
      cwCnt_ff <= {`VCBS_CW_CNT_W{1'b0}};
      cwActive <= `VCBS_CW_RESET;
    end
    else
    begin
      state_ff <= nxt_state;
      if (state_ff == ST_IDLE)
        cwCnt_ff <= {`VCBS_CW_CNT_W{1'b0}};
      else if (cwStrobe)
      begin
        cwShift_ff <= {cwShift_ff[`VCBS_CW_BITS-2:0], cwBit};
        cwCnt_ff <= cwCnt_ff + 1'b1;
        if (cwCnt_ff == `VCBS_CW_BITS - 1)
          cwActive <= {cwShift_ff[`VCBS_CW_BITS-2:0], cwBit};
      end
    end
  end

  // ---------------------------------------------------------------
  // Validity combining
  // ---------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g < `VCBS_NUM_TRK; g = g + 1)
    begin : gen_val
      // Partners 0/2, 1/3, 4/6, 5/7
      assign pairOr[g] = chanValid[g] | chanValid[g ^ 2];
      assign adjOr[g] = pairOr[g] | pairOr[g ^ 1];
    end
  endgenerate

  always @*
  begin
    validOut = chanValid;
    if (polarMode && swapSel)
      validOut = adjOr;
    else if (polarMode)
      validOut = chanValid | {chanValid[6], chanValid[7], chanValid[4], chanValid[5],
                              chanValid[2], chanValid[3], chanValid[0], chanValid[1]};
  end

  // ---------------------------------------------------------------
  // Bit shuffle multiplexers
  // ---------------------------------------------------------------
  always @*
  begin : mux_blk
    integer m;
    muxOut = {`VCBS_OUT_W{1'b0}};
    for (m = 0; m < `VCBS_NUM_MUX; m = m + 1)
      muxOut[m] = trackPick(variantSel, m, selField(cwActive, m), trackBits);
  end

  vcbs_skid_buf #(.WIDTH(`VCBS_OUT_W + `VCBS_NUM_TRK)) u_buf
  (
    .clk(clk),
    .rst_b(rst_b),
    .inData({validOut, muxOut}),
    .inValid(inValid),
    .inReady(inReady),
    .outData({bankValidity, bankBits}),
    .outValid(outValid),
    .outReady(outReady)
  );
endmodule

// ==== vcbs_props.sv ====
// Checker on the block ports
`timescale 1ns/1ps
module vcbs_props
(
  input wire clk,
  input wire rst_b,
  input wire [7:0] trackBits,
  input wire [7:0] chanValid,
  input wire polarMode,
  input wire swapSel,
  input wire [1:0] variantSel,
  input wire cwStrobe,
  input wire inValid,
  input wire inReady,
  input wire [7:0] bankBits,
  input wire [7:0] bankValidity,
  input wire outValid,
  input wire outReady,
  input wire [31:0] cwActive
);
  wire tk = inValid && inReady && !outValid;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  property p_cw; $changed(cwActive) |-> $past(cwStrobe); endproperty
  a_cw: assert property (p_cw) else $error("cw");
  property p_st; outValid && !outReady |=> $stable(bankBits) && $stable(bankValidity); endproperty
  a_st: assert property (p_st) else $error("st");
  property p_hd; outValid && !outReady |=> outValid; endproperty
  a_hd: assert property (p_hd) else $error("hd");
  property p_lat; inValid && inReady |=> outValid; endproperty
  a_lat: assert property (p_lat) else $error("lat");
  property p_rdy; $past(rst_b) && !inReady |-> outValid; endproperty
  a_rdy: assert property (p_rdy) else $error("rdy");
  property p_pass; tk && !polarMode |=> bankValidity == $past(chanValid); endproperty
  a_pass: assert property (p_pass) else $error("pass");
  property p_dir; tk && variantSel == 2'h0 |=> bankBits[0] == $past(trackBits[cwActive[2:0]]);
  endproperty
  a_dir: assert property (p_dir) else $error("dir");
  property p_or; tk && polarMode |=> bankValidity[0] == $past(|(chanValid & {4'h0, swapSel,
    swapSel, 2'h3})); endproperty
  a_or: assert property (p_or) else $error("or");
endmodule

// ==== vcbs_sink.sv ====
// Downstream consumer that stalls at random
`timescale 1ns/1ps
module vcbs_sink
(
  input wire clk,
  input wire hold,
  output reg outReady
);
  initial outReady = 1'b0;
  always @(posedge clk) outReady <= #1 !hold && ($urandom % 4 != 0);
endmodule

// ==== vcbs_validity_shuffle_test.sv ====
// Bench for the validity combine and bit shuffle block
`timescale 1ns/1ps
module vcbs_validity_shuffle_test;
  reg clk = 0, rst_b = 0, polarMode = 0, swapSel = 0, cwBit = 0, cwStrobe = 0;
  reg cwStart = 0, inValid = 0, hold = 0, ok;
  reg [7:0] trackBits = 0, chanValid = 0;
  reg [1:0] variantSel = 0;
  reg [31:0] cw = 0, w;
  wire inReady, outValid, outReady;
  wire [7:0] bankBits, bankValidity;
  wire [31:0] cwActive;
  reg [15:0] q[$];
  integer bad_count = 0, total_checks = 0, cyc = 0, ph, n, k, m;
  always #2 clk = !clk;
  vcbs_validity_shuffle dut (.*);
  vcbs_sink sink (.*);
  function [7:0] eb(input [7:0] t);
    reg [2:0] s;
    for (m = 0; m < 8; m = m + 1)
    begin
      s = cw[4*m +: 3];
      if (variantSel == 2'h1) s = {s[1:0], s[2]};
      if (variantSel[1]) s = variantSel[0] ? 3'h0 : {2'h0, m[0]};
      eb[m] = t[s];
    end
  endfunction
  function [7:0] ev(input [7:0] c);
    if (polarMode) c = c | {c[6], c[7], c[4], c[5], c[2], c[3], c[0], c[1]};
    if (polarMode && swapSel) c = c | {c[5:4], c[7:6], c[1:0], c[3:2]};
    ev = c;
  endfunction
  task chk(input [31:0] g, e);
    total_checks = total_checks + 1;
    if (g !== e)
    begin
      bad_count = bad_count + 1;
      $display("unexpected %0t %h %h", $time, g, e);
    end
  endtask
  task finish_test;
    if (bad_count == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(posedge clk)
  begin
    cyc = cyc + 1;
    if (cyc == 6000)
    begin
      bad_count = bad_count + 1;
      finish_test;
    end
  end
  always @(negedge clk)
    if (outValid && outReady)
    begin
      chk(bankBits & (variantSel == 2'h2 ? 8'hf0 : 8'hff), q[0][15:8]);
      chk(bankValidity, q[0][7:0]);
      q.delete(0);
    end
  initial
  begin
    w = $urandom(97042);
    repeat (12) @(posedge clk);
    #1 rst_b = 1;
    repeat (2) @(posedge clk);
    for (ph = 0; ph < 8; ph = ph + 1)
    begin
      #1 {polarMode, variantSel} = ph;
      swapSel = ph[0];
      hold = ph == 3;
      w = $urandom;
      cwStart = 1;
      @(posedge clk);
      #1 cwStart = 0;
      for (k = 31; k >= 0; k = k - 1)
      begin
        if (k == 0) chk(cwActive, cw);
        {cwStrobe, cwBit} = {1'b1, w[k]};
        @(posedge clk);
        #1;
      end
      cwStrobe = 0;
      cw = w;
      chk(cwActive, cw);
      n = 0;
      repeat (24)
      begin
        w = $urandom;
        trackBits = w[7:0];
        if (variantSel[1]) trackBits = variantSel[0] ? w[7:0] & 8'haa | {4{1'b0, w[0]}} : {4{w[1:0]}};
        chanValid = w[15:8];
        if (polarMode) chanValid = chanValid | {chanValid[6], chanValid[7], chanValid[4],
          chanValid[5], chanValid[2], chanValid[3], chanValid[0], chanValid[1]};
        inValid = 1;
        ok = 0;
        for (k = 0; k < 6 && !ok; k = k + 1)
        begin
          ok = inReady;
          @(posedge clk);
          #1;
        end
        if (ok) q.push_back({eb(trackBits) & (variantSel == 2'h2 ? 8'hf0 : 8'hff), ev(chanValid)});
        n = n + ok;
      end
      inValid = 0;
      if (hold) chk(n, 2);
      hold = 0;
      for (k = 0; k < 99 && q.size() > 0; k = k + 1) @(posedge clk);
      chk(q.size(), 0);
    end
    finish_test;
  end
endmodule
bind vcbs_validity_shuffle vcbs_props chk_i (.*);
